// >>> core/fcse_flash_ctrl.sv
// Flash command controller: Wishbone registers, command sequencer, toggle polling
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
module fcse_flash_ctrl #(
  parameter logic [7:0] PGM_CMD = 8'ha0
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic [18:0]      flash_addr,
  input  wire logic [7:0]  flash_dq_i,
  output logic [7:0]       flash_dq_o,
  output logic             flash_dq_oe,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n
);
  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_WR    = 5'b00010,
    S_POLL  = 5'b00100,
    S_FINAL = 5'b01000,
    S_RST   = 5'b10000
  } fcse_st_t;

  fcse_st_t    st_q;
  logic [2:0]  op_q;
  logic [2:0]  step_q;
  logic [18:0] addr_q;
  logic [7:0]  wdata_q;
  logic [7:0]  rdata_q;
  logic [7:0]  stat_q;
  logic [7:0]  bad_q;
  logic        fail_q;
  logic        refused_q;
  logic        wait_q;
  logic        req_q;
  logic        cyc_we_q;
  logic [26:0] cyc_word_q;
  logic        prev_tog_q;
  logic        have_prev_q;
  logic        fail_seen_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic        bus_req;
  logic        bus_wr;
  logic        ctrl_wr;
  logic        op_ok;
  logic        bad_hit;
  logic        start_ok;
  logic        tog_same;
  logic        fail_set;
  logic [26:0] iss_word;
  logic        iss_we;

  fcse_cyc_if cyc ();

  function automatic logic [26:0] seq_word(input logic [2:0]  op,
                                           input logic [2:0]  step,
                                           input logic [18:0] a,
                                           input logic [7:0]  d);
    logic [7:0] setup;
    setup = (op == fcse_pkg::OP_PROG)  ? PGM_CMD :
            (op == fcse_pkg::OP_RESET) ? fcse_pkg::CMD_RESET : fcse_pkg::CMD_ERASE_SETUP;
    case (step)
      3'h0: seq_word = {fcse_pkg::UNL_ADDR1, fcse_pkg::UNL_DATA1};
      3'h1: seq_word = {fcse_pkg::UNL_ADDR2, fcse_pkg::UNL_DATA2};
      3'h2: seq_word = {fcse_pkg::UNL_ADDR1, setup};
      3'h3: seq_word = (op == fcse_pkg::OP_PROG) ? {a, d} :
                       {fcse_pkg::UNL_ADDR1, fcse_pkg::UNL_DATA1};
      3'h4: seq_word = {fcse_pkg::UNL_ADDR2, fcse_pkg::UNL_DATA2};
      3'h5: seq_word = (op == fcse_pkg::OP_SERASE) ? {a, fcse_pkg::CMD_SECT_CONF} :
                       {fcse_pkg::UNL_ADDR1, fcse_pkg::CMD_BULK_CONF};
      default: seq_word = {fcse_pkg::UNL_ADDR1, fcse_pkg::CMD_RESET};
    endcase
  endfunction : seq_word

  function automatic logic [2:0] last_step(input logic [2:0] op);
    case (op)
      fcse_pkg::OP_PROG:  last_step = 3'h3;
      fcse_pkg::OP_RESET: last_step = 3'h2;
      default:            last_step = 3'h5;
    endcase
  endfunction : last_step

  assign bus_req  = wb_cyc_i && wb_stb_i && !ack_q;
  assign bus_wr   = bus_req && wb_we_i && wb_sel_i[0];
  assign ctrl_wr  = bus_wr && (wb_adr_i == fcse_pkg::OFS_CTRL);
  assign op_ok    = (wb_dat_i[2:0] >= fcse_pkg::OP_READ) && (wb_dat_i[2:0] <= fcse_pkg::OP_RESET);
  // A sector that once failed is fenced off from program and sector erase until software clears its bit
  assign bad_hit  = bad_q[addr_q[fcse_pkg::SECT_MSB:fcse_pkg::SECT_LSB]] &&
                    ((wb_dat_i[2:0] == fcse_pkg::OP_PROG) ||
                     (wb_dat_i[2:0] == fcse_pkg::OP_SERASE));
  assign start_ok = ctrl_wr && (st_q == S_IDLE) && op_ok && !bad_hit;
  assign tog_same = have_prev_q && (cyc.rdata[fcse_pkg::TOG_BIT] == prev_tog_q);
  assign fail_set = (st_q == S_POLL) && wait_q && cyc.done && !tog_same && fail_seen_q;

  assign cyc.req   = req_q;
  assign cyc.we    = cyc_we_q;
  assign cyc.addr  = cyc_word_q[26:8];
  assign cyc.wdata = cyc_word_q[7:0];
  assign wb_ack_o  = ack_q;
  assign wb_dat_o  = dat_q;

  always_comb begin
    iss_word = {addr_q, 8'h00};
    iss_we   = 1'b0;
    case (st_q)
      S_WR: begin
        iss_word = seq_word(op_q, step_q, addr_q, wdata_q);
        iss_we   = 1'b1;
      end
      S_RST: begin
        iss_word = {fcse_pkg::UNL_ADDR1, fcse_pkg::CMD_RESET};
        iss_we   = 1'b1;
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q        <= S_IDLE;
      step_q      <= 3'h0;
      wait_q      <= 1'b0;
      req_q       <= 1'b0;
      cyc_we_q    <= 1'b0;
      cyc_word_q  <= 27'h0000000;
      prev_tog_q  <= 1'b0;
      have_prev_q <= 1'b0;
      fail_seen_q <= 1'b0;
      stat_q      <= 8'h00;
      rdata_q     <= 8'h00;
    end else begin
      req_q <= 1'b0;
      if ((st_q != S_IDLE) && !wait_q) begin
        req_q      <= 1'b1;
        wait_q     <= 1'b1;
        cyc_we_q   <= iss_we;
        cyc_word_q <= iss_word;
      end
      case (st_q)
        S_IDLE: if (start_ok) begin
          step_q      <= 3'h0;
          have_prev_q <= 1'b0;
          fail_seen_q <= 1'b0;
          st_q        <= (wb_dat_i[2:0] == fcse_pkg::OP_READ) ? S_FINAL : S_WR;
        end
        S_WR: if (wait_q && cyc.done) begin
          wait_q <= 1'b0;
          if (step_q == last_step(op_q)) begin
            // Polling only after the last command write, when status is valid
            st_q <= (op_q == fcse_pkg::OP_RESET) ? S_IDLE : S_POLL;
          end else begin
            step_q <= step_q + 3'h1;
          end
        end
        S_POLL: if (wait_q && cyc.done) begin
          wait_q      <= 1'b0;
          stat_q      <= cyc.rdata & fcse_pkg::STAT_MASK;
          prev_tog_q  <= cyc.rdata[fcse_pkg::TOG_BIT];
          have_prev_q <= 1'b1;
          fail_seen_q <= cyc.rdata[fcse_pkg::FAIL_BIT];
          // Fail is only trusted when the toggle still runs after the fail bit
          if (tog_same) begin
            st_q <= S_FINAL;
          end else if (fail_seen_q) begin
            st_q <= S_RST;
          end
        end
        S_FINAL: if (wait_q && cyc.done) begin
          wait_q  <= 1'b0;
          rdata_q <= cyc.rdata;
          st_q    <= S_IDLE;
        end
        S_RST: if (wait_q && cyc.done) begin
          wait_q <= 1'b0;
          st_q   <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_q    <= 3'h0;
      addr_q  <= 19'h00000;
      wdata_q <= 8'h00;
    end else begin
      if (start_ok) begin
        op_q <= wb_dat_i[2:0];
      end
      if (bus_wr && (wb_adr_i == fcse_pkg::OFS_ADDR) && (st_q == S_IDLE)) begin
        addr_q <= wb_dat_i[18:0];
      end
      if (bus_wr && (wb_adr_i == fcse_pkg::OFS_DATA) && (st_q == S_IDLE)) begin
        wdata_q <= wb_dat_i[7:0];
      end
    end
  end

  // Hardware set wins over a same-cycle clear on every sticky flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fail_q    <= 1'b0;
      refused_q <= 1'b0;
      bad_q     <= 8'h00;
    end else begin
      fail_q    <= fail_set || (fail_q && !start_ok);
      refused_q <= (ctrl_wr && !start_ok) || (refused_q && !start_ok);
      bad_q     <= (bad_q & ~((bus_wr && (wb_adr_i == fcse_pkg::OFS_BAD_SECT)) ?
                              wb_dat_i[7:0] : 8'h00)) |
                   ((fail_set && (op_q != fcse_pkg::OP_BERASE)) ?
                    (8'h01 << addr_q[fcse_pkg::SECT_MSB:fcse_pkg::SECT_LSB]) : 8'h00);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= bus_req;
      if (bus_req && !wb_we_i) begin
        case (wb_adr_i)
          fcse_pkg::OFS_CTRL:     dat_q <= {29'h0, op_q};
          fcse_pkg::OFS_ADDR:     dat_q <= {13'h0, addr_q};
          fcse_pkg::OFS_DATA:     dat_q <= {24'h0, rdata_q};
          fcse_pkg::OFS_STATUS:   dat_q <= {16'h0, stat_q, 5'h0, refused_q, fail_q,
                                            st_q != S_IDLE};
          fcse_pkg::OFS_BAD_SECT: dat_q <= {24'h0, bad_q};
          default:                dat_q <= 32'h00000000;
        endcase
      end
    end
  end

  fcse_pin_cycle u_pins (
    .clk         (clk),
    .rst_n       (rst_n),
    .cyc         (cyc.engine),
    .flash_addr  (flash_addr),
    .flash_dq_i  (flash_dq_i),
    .flash_dq_o  (flash_dq_o),
    .flash_dq_oe (flash_dq_oe),
    .flash_ce_n  (flash_ce_n),
    .flash_oe_n  (flash_oe_n),
    .flash_we_n  (flash_we_n)
  );

  chk_unlock_first: assert property (
    @(posedge clk) disable iff (!rst_n)
    cyc.req && (st_q == S_WR) && (step_q == 3'h0) |->
      (cyc.addr == fcse_pkg::UNL_ADDR1) && (cyc.wdata == fcse_pkg::UNL_DATA1) ##1
      !cyc.req [*4] ##1 (step_q == 3'h1))
    else $error("first unlock write wrong or second step late");

  chk_erase_reunlock: assert property (
    @(posedge clk) disable iff (!rst_n)
    cyc.req && (st_q == S_WR) && (step_q == 3'h4) |->
      (cyc.addr == fcse_pkg::UNL_ADDR2) && (cyc.wdata == fcse_pkg::UNL_DATA2) &&
      (op_q != fcse_pkg::OP_PROG))
    else $error("erase confirm not preceded by second unlock");

  chk_poll_after_last: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(st_q == S_POLL) |-> $past(step_q) == last_step(op_q) ##[1:2]
      (cyc.req && !cyc.we && (cyc.addr == addr_q)))
    else $error("poll started early or at wrong address");

  chk_status_mask: assert property (
    @(posedge clk) disable iff (!rst_n)
    (stat_q & ~fcse_pkg::STAT_MASK) == 8'h00)
    else $error("reserved status bits not masked");

  chk_finish_two: assert property (
    @(posedge clk) disable iff (!rst_n)
    (st_q == S_POLL) && cyc.done && have_prev_q &&
      (cyc.rdata[fcse_pkg::TOG_BIT] == prev_tog_q) |=> (st_q == S_FINAL) ##[1:8] cyc.done)
    else $error("equal toggle reads did not end polling");

  chk_bad_refused: assert property (
    @(posedge clk) disable iff (!rst_n)
    ctrl_wr && (st_q == S_IDLE) && bad_hit |=> (st_q == S_IDLE) && refused_q)
    else $error("operation on failed sector was started");

  chk_fail_reset: assert property (
    @(posedge clk) disable iff (!rst_n)
    fail_set |=> (st_q == S_RST) && fail_q ##[1:8]
      (cyc.req && cyc.we && (cyc.wdata == fcse_pkg::CMD_RESET)))
    else $error("failure not followed by read/reset write");

  chk_reset_word: assert property (
    @(posedge clk) disable iff (!rst_n)
    cyc.req && (st_q == S_WR) && (op_q == fcse_pkg::OP_RESET) && (step_q == 3'h2) |->
      (cyc.addr == fcse_pkg::UNL_ADDR1) && (cyc.wdata == fcse_pkg::CMD_RESET))
    else $error("read/reset command word wrong");
endmodule : fcse_flash_ctrl

// >>> core/fcse_pkg.sv
// Constants, register map and command codes for the flash command controller
package fcse_pkg;
  localparam logic [7:0]  OFS_CTRL        = 8'h00;
  localparam logic [7:0]  OFS_ADDR        = 8'h04;
  localparam logic [7:0]  OFS_DATA        = 8'h08;
  localparam logic [7:0]  OFS_STATUS      = 8'h0c;
  localparam logic [7:0]  OFS_BAD_SECT    = 8'h10;

  localparam logic [2:0]  OP_READ         = 3'h1;
  localparam logic [2:0]  OP_PROG         = 3'h2;
  localparam logic [2:0]  OP_SERASE       = 3'h3;
  localparam logic [2:0]  OP_BERASE       = 3'h4;
  localparam logic [2:0]  OP_RESET        = 3'h5;

  localparam logic [18:0] UNL_ADDR1       = 19'h05555;
  localparam logic [18:0] UNL_ADDR2       = 19'h02aaa;
  localparam logic [7:0]  UNL_DATA1       = 8'haa;
  localparam logic [7:0]  UNL_DATA2       = 8'h55;
  localparam logic [7:0]  CMD_RESET       = 8'hf0;
  localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0]  CMD_SECT_CONF   = 8'h30;
  localparam logic [7:0]  CMD_BULK_CONF   = 8'h10;

  localparam logic [7:0]  STAT_MASK       = 8'he8;
  localparam int          TOG_BIT         = 6;
  localparam int          FAIL_BIT        = 5;
  localparam int          SECT_MSB        = 18;
  localparam int          SECT_LSB        = 16;

  localparam int          CLK_NS          = 100;
  localparam int          T_WP_NS         = 50;
  localparam int          T_ACC_NS        = 150;
  localparam int          SYNC_STAGES     = 2;
  localparam int          WP_CYC          = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int          ACC_CYC         = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0]  WP_CNT          = 3'(((WP_CYC < 1) ? 1 : WP_CYC) - 1);
  localparam logic [2:0]  RD_CNT          = 3'(ACC_CYC + SYNC_STAGES - 1);
endpackage : fcse_pkg

// >>> core/fcse_cyc_if.sv
// One flash bus cycle request and its answer, between sequencer and pin engine
`timescale 1ns/100ps
interface fcse_cyc_if;
  logic        req;
  logic        we;
  logic [18:0] addr;
  logic [7:0]  wdata;
  logic        done;
  logic [7:0]  rdata;
  modport master (output req, we, addr, wdata, input done, rdata);
  modport engine (input req, we, addr, wdata, output done, rdata);
endinterface : fcse_cyc_if

// >>> core/fcse_pin_cycle.sv
// Pin engine: turns one request into a write or read cycle on the flash pins
`timescale 1ns/100ps
module fcse_pin_cycle (
  input  wire logic        clk,
  input  wire logic        rst_n,
  fcse_cyc_if.engine       cyc,
  output logic [18:0]      flash_addr,
  input  wire logic [7:0]  flash_dq_i,
  output logic [7:0]       flash_dq_o,
  output logic             flash_dq_oe,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n
);
  typedef enum logic [4:0] {
    P_IDLE   = 5'b00001,
    P_SET    = 5'b00010,
    P_STROBE = 5'b00100,
    P_HOLD   = 5'b01000,
    P_READ   = 5'b10000
  } fcse_pst_t;

  fcse_pst_t  st_q;
  logic [2:0] cnt_q;
  logic [7:0] dq_s1_q;
  logic [7:0] dq_s2_q;
  logic       done_q;
  logic [7:0] rdata_q;

  assign cyc.done  = done_q;
  assign cyc.rdata = rdata_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
    end else begin
      dq_s1_q <= flash_dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  // Address is set a full cycle before the strobe falls and data is held
  // until a cycle after it rises, so both device edges see stable values
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q        <= P_IDLE;
      cnt_q       <= 3'h0;
      done_q      <= 1'b0;
      rdata_q     <= 8'h00;
      flash_addr  <= 19'h00000;
      flash_dq_o  <= 8'h00;
      flash_dq_oe <= 1'b0;
      flash_ce_n  <= 1'b1;
      flash_oe_n  <= 1'b1;
      flash_we_n  <= 1'b1;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        P_IDLE: if (cyc.req) begin
          flash_addr <= cyc.addr;
          flash_dq_o <= cyc.wdata;
          flash_ce_n <= 1'b0;
          if (cyc.we) begin
            flash_dq_oe <= 1'b1;
            st_q        <= P_SET;
          end else begin
            flash_oe_n <= 1'b0;
            cnt_q      <= fcse_pkg::RD_CNT;
            st_q       <= P_READ;
          end
        end
        P_SET: begin
          flash_we_n <= 1'b0;
          cnt_q      <= fcse_pkg::WP_CNT;
          st_q       <= P_STROBE;
        end
        P_STROBE: begin
          if (cnt_q == 3'h0) begin
            flash_we_n <= 1'b1;
            st_q       <= P_HOLD;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        P_HOLD: begin
          flash_ce_n  <= 1'b1;
          flash_dq_oe <= 1'b0;
          done_q      <= 1'b1;
          st_q        <= P_IDLE;
        end
        P_READ: begin
          if (cnt_q == 3'h0) begin
            rdata_q    <= dq_s2_q;
            flash_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            done_q     <= 1'b1;
            st_q       <= P_IDLE;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        default: st_q <= P_IDLE;
      endcase
    end
  end

  chk_strobe_width: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(flash_we_n) |-> flash_dq_oe && !flash_ce_n ##1 flash_we_n && flash_dq_oe)
    else $error("write strobe not one cycle with data driven");

  chk_read_pulse: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(flash_oe_n) |-> !flash_dq_oe throughout (##[4:4] $rose(flash_oe_n)))
    else $error("read pulse length wrong or bus driven during read");
endmodule : fcse_pin_cycle

// >>> verif/fcse_flash_model.sv
// Behavioural flash device facing the controller's pins
`timescale 1ns/100ps
module fcse_flash_model #(
  parameter logic [7:0] PGM_CMD = 8'ha0,
  parameter int         BUSY_RD = 3
) (
  input  wire logic [18:0] flash_addr,
  input  wire logic [7:0]  flash_dq_o,
  input  wire logic        flash_dq_oe,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_we_n,
  input  wire logic [7:0]  prot,
  input  wire logic        fail_inj,
  output logic [7:0]       dq,
  output int               clash
);
  logic [7:0]  mem [int];
  logic [18:0] a_q;
  logic [7:0]  pd_q;
  logic [7:0]  drv_q;
  logic        tog_q;
  logic        fail_q;
  logic        ers_q;
  logic        win_q;
  int          st_q;
  int          left_q;
  initial begin
    st_q = 0;
    left_q = 0;
    tog_q = 1'b0;
    fail_q = 1'b0;
    win_q = 1'b1;
    ers_q = 1'b0;
    pd_q = 8'h00;
    clash = 0;
    drv_q = 8'ha5;
    dq = 8'h5a;
  end
  function automatic logic [7:0] rd_mem(input logic [18:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction : rd_mem
  task automatic go();
    left_q = BUSY_RD;
    fail_q = fail_inj;
  endtask : go
  task automatic erase(input logic bulk);
    logic [7:0] sel;
    int         ks [$];
    sel = bulk ? 8'hff : 8'h01 << a_q[18:16];
    ers_q = 1'b1;
    win_q = 1'b0;
    if ((sel & ~prot) == 8'h00) begin
      left_q = BUSY_RD;
    end else begin
      foreach (mem[k]) ks.push_back(k);
      foreach (ks[i]) if (sel[ks[i][18:16]] && !prot[ks[i][18:16]]) mem.delete(ks[i]);
      go();
    end
  endtask : erase
  always @(negedge flash_we_n) if (!flash_ce_n) a_q = flash_addr;
  always @(posedge flash_we_n) begin : cmd
    logic [7:0] d;
    d = flash_dq_o;
    if (!flash_ce_n && d == 8'hf0 && (st_q == 0 || st_q == 2)) begin
      fail_q = 1'b0;
      left_q = 0;
      st_q = 0;
    end else if (!flash_ce_n && left_q > 0) begin
      st_q = 0;
    end else if (!flash_ce_n) begin
      case (st_q)
        0, 3: st_q = (a_q == 19'h05555 && d == 8'haa) ? st_q + 1 : 0;
        1, 4: st_q = (a_q == 19'h02aaa && d == 8'h55) ? st_q + 1 : 0;
        2: st_q = (a_q != 19'h05555) ? 0 : (d == PGM_CMD) ? 10 : (d == 8'h80) ? 3 : 0;
        5: begin
          st_q = 0;
          if (d == 8'h30 || d == 8'h10) erase(d == 8'h10);
        end
        10: begin
          st_q = 0;
          if (!prot[a_q[18:16]]) begin
            mem[a_q] = rd_mem(a_q) & d;
            pd_q = d;
            ers_q = 1'b0;
            go();
          end
        end
        default: st_q = 0;
      endcase
    end
  end
  // Data appears only after an access delay, so an early sample sees junk
  always @(negedge flash_oe_n) if (!flash_ce_n) begin : rd
    logic [7:0] v;
    if (flash_dq_oe || (left_q > 0 && !ers_q && flash_addr != a_q)) clash++;
    if (left_q > 0) begin
      tog_q = ~tog_q;
      v = {ers_q ? 1'b0 : ~pd_q[7], tog_q, fail_q, ~tog_q, win_q, tog_q, ~tog_q, tog_q};
      win_q = 1'b1;
      if (!fail_q) left_q--;
    end else begin
      v = rd_mem(flash_addr);
    end
    #120 if (!flash_oe_n && !flash_ce_n) begin
      drv_q = v;
      dq = v;
    end
  end
  // Released bus shows the inverse of the last byte; safe if both strobes rise together
  always @(posedge flash_oe_n or posedge flash_ce_n) dq = ~drv_q;
endmodule : fcse_flash_model

// >>> verif/fcse_flash_ctrl_tb.sv
// Self-checking bench: controller against a behavioural flash and reference array
`timescale 1ns/100ps
module fcse_flash_ctrl_tb;
  logic        clk, rst_n, cyc, stb, we, ack, ce_n, oe_n, we_n, dq_oe, fail_inj;
  logic [7:0]  adr, dq, dq_o, prot;
  logic [31:0] wdat, rdat, rd;
  logic [3:0]  sel;
  logic [18:0] faddr, a;
  logic [7:0]  ref_mem [int];
  int          error_cnt, comparisons, clash;
  fcse_flash_ctrl dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .flash_addr(faddr), .flash_dq_i(dq), .flash_dq_o(dq_o),
    .flash_dq_oe(dq_oe), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n));
  fcse_flash_model flash_u (.flash_addr(faddr), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .prot(prot),
    .fail_inj(fail_inj), .dq(dq), .clash(clash));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    sel <= 4'h1 | 4'($urandom);
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) error_cnt++;
  endtask : wb
  task automatic run_op(input logic [2:0] op, input logic [18:0] ta, input logic [7:0] d,
                        input logic dup);
    int n;
    n = 0;
    wb(1'b1, fcse_pkg::OFS_ADDR, 32'(ta));
    wb(1'b1, fcse_pkg::OFS_DATA, 32'(d));
    wb(1'b1, fcse_pkg::OFS_CTRL, 32'(op));
    if (dup) wb(1'b1, fcse_pkg::OFS_CTRL, 32'(op));
    do begin
      wb(1'b0, fcse_pkg::OFS_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 500);
    if (n >= 500) error_cnt++;
  endtask : run_op
  function automatic logic [7:0] ref_rd(input logic [18:0] ra);
    return ref_mem.exists(ra) ? ref_mem[ra] : 8'hff;
  endfunction : ref_rd
  task automatic ref_erase(input logic [7:0] s);
    int ks [$];
    foreach (ref_mem[k]) ks.push_back(k);
    foreach (ks[i]) if (s[ks[i][18:16]] && !prot[ks[i][18:16]]) ref_mem.delete(ks[i]);
  endtask : ref_erase
  task automatic read_back(input logic [18:0] ra);
    run_op(fcse_pkg::OP_READ, ra, 8'h00, 1'b0);
    wb(1'b0, fcse_pkg::OFS_DATA, 32'h0);
    chk_word(rd, 32'(ref_rd(ra)));
  endtask : read_back
  initial begin
    #4_000_000;
    error_cnt++;
    complete_run();
  end
  initial begin
    logic [7:0] d;
    {rst_n, cyc, stb, we, fail_inj} = 5'b0;
    {adr, wdat, sel} = '0;
    prot = 8'h40;
    error_cnt = 0;
    comparisons = 0;
    void'($urandom(32'h9303));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk_word({ce_n, oe_n, we_n, dq_oe}, 32'he);
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0);
      chk_word(rd, 32'h0);
    end
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      a = {3'($urandom_range(5, 0)), 16'($urandom)};
      d = 8'($urandom);
      run_op(fcse_pkg::OP_PROG, a, d, 1'b0);
      ref_mem[a] = ref_rd(a) & d;
      chk_word(rd & 32'h1707, 32'h0);
      wb(1'b0, fcse_pkg::OFS_DATA, 32'h0);
      chk_word(rd, 32'(ref_mem[a]));
      read_back(a);
    end
    $display("test program done");
    run_op(fcse_pkg::OP_PROG, 19'h6_1234, 8'h00, 1'b0);
    read_back(19'h6_1234);
    run_op(fcse_pkg::OP_SERASE, a, 8'h00, 1'b0);
    ref_erase(8'h01 << a[18:16]);
    chk_word(rd & 32'h7, 32'h0);
    read_back(a);
    run_op(fcse_pkg::OP_SERASE, 19'h6_0000, 8'h00, 1'b0);
    chk_word(rd & 32'h7, 32'h0);
    run_op(fcse_pkg::OP_BERASE, 19'h0_0000, 8'h00, 1'b0);
    // Keep erased keys as ff so every byte left in ref_mem from the earlier programs is read back
    foreach (ref_mem[k]) if (!prot[k[18:16]]) ref_mem[k] = 8'hff;
    foreach (ref_mem[k]) read_back(19'(k));
    read_back(a);
    ref_erase(8'hff);
    $display("test erase done");
    run_op(fcse_pkg::OP_PROG, 19'h1_0040, 8'h3c, 1'b1);
    ref_mem[19'h1_0040] = 8'h3c;
    chk_word(rd & 32'h7, 32'h4);
    for (int op = 0; op < 8; op += (op == 0) ? 6 : 1) begin
      // An accepted start clears refused, so each bad code must set it anew
      run_op(fcse_pkg::OP_READ, 19'h1_0040, 8'h00, 1'b0);
      chk_word(rd & 32'h7, 32'h0);
      wb(1'b1, fcse_pkg::OFS_CTRL, 32'(op));
      wb(1'b0, fcse_pkg::OFS_STATUS, 32'h0);
      chk_word(rd & 32'h7, 32'h4);
    end
    $display("test refusal done");
    fail_inj <= 1'b1;
    run_op(fcse_pkg::OP_PROG, 19'h2_0100, 8'h0f, 1'b0);
    fail_inj <= 1'b0;
    chk_word(rd & 32'h3, 32'h2);
    wb(1'b0, fcse_pkg::OFS_BAD_SECT, 32'h0);
    chk_word(rd, 32'h4);
    run_op(fcse_pkg::OP_PROG, 19'h2_0200, 8'h0f, 1'b0);
    chk_word(rd & 32'h7, 32'h6);
    wb(1'b1, fcse_pkg::OFS_BAD_SECT, 32'h4);
    wb(1'b0, fcse_pkg::OFS_BAD_SECT, 32'h0);
    chk_word(rd, 32'h0);
    run_op(fcse_pkg::OP_RESET, 19'h0, 8'h00, 1'b0);
    chk_word(rd & 32'h7, 32'h0);
    read_back(19'h1_0040);
    $display("test fail done");
    chk_word(32'(clash), 32'h0);
    complete_run();
  end
endmodule : fcse_flash_ctrl_tb
